// >>> activity_power_mode_sequencer.sv
// Activity-driven power-mode sequencer with radio power-down controls.
// Assumes all inputs synchronous to clk; rst_n asynchronous, active low.
//
// Functional notes
// - Four modes: active, idle, sleep, deep power-off, highest to lowest.
// - Inactivity for programmed period steps down one mode.
// - Any activity in a lower mode returns straight to active.
// - Deep power-off disables core supply output and amplifier supply.
// - I/O domain keeps watching events in power-off and wakes chip.
// - Core regulator is turned off in deep power-off.
// - Separate power-down outputs for transmit, receive, PLL, amplifier.
// - Radio enabled only inside packet transmit or receive intervals.
// - Low-power connection mode runs on slow clock, wakes on interval.
// - Power controllable by software writes and baseband packet events.
// - Device drives device-to-host wake when it needs the host, except in deep power-off.
// - Warm-up extend input lengthens crystal warm-up for clock requests.
`timescale 1ns/1ps
module activity_power_mode_sequencer #(
    parameter int IDLE_TIMEOUT  = power_mode_pkg::IDLE_TIMEOUT_CYC,
    parameter int WAKE_INTERVAL = power_mode_pkg::WAKE_INTERVAL_CYC
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Activity and software control
    input  wire logic user_activity,
    input  wire logic sw_force_active,
    input  wire logic sw_force_step,
    input  wire logic lp_conn_enable,
    // Baseband packet events
    input  wire logic pkt_tx_active,
    input  wire logic pkt_rx_active,
    // Host wake handshake and clock request
    input  wire logic host_to_device_wake,
    input  wire logic dev_attention,
    input  wire logic warmup_extend_input,
    input  wire logic clk_request,
    // Supplies and mode
    output logic [1:0] power_mode,
    output logic       core_supply_output_en,
    output logic       amplifier_supply_en,
    output logic       core_regulator_en,
    output logic       slow_clock_sel,
    // Radio power-down controls
    output logic       tx_pd,
    output logic       rx_pd,
    output logic       pll_pd,
    output logic       pa_pd,
    // Host and clock
    output logic       device_to_host_wake,
    output logic       clk_ready
);

    // ====================================================================
    // Reset release through two flops
    logic rst_s1_reg, rst_sync_n;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_reg <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_sync_n <= rst_s1_reg;
        end
    end

    // ====================================================================
    // Mode sequencer
    power_mode_pkg::power_mode_type mode_reg, mode_next;
    logic [power_mode_pkg::TIMER_W-1:0] idle_cnt_reg, idle_cnt_next;
    logic [power_mode_pkg::TIMER_W-1:0] wake_cnt_reg, wake_cnt_next;
    logic [power_mode_pkg::TIMER_W-1:0] warm_cnt_reg, warm_cnt_next;
    logic wake_event;
    logic timeout;
    logic [power_mode_pkg::TIMER_W-1:0] warm_target;

    // Host wake counts as user activity: it is watched in every mode,
    // including power-off, since the I/O domain never loses power
    assign wake_event = user_activity | host_to_device_wake
                      | sw_force_active;
    assign timeout = (idle_cnt_reg
                      == power_mode_pkg::TIMER_W'(IDLE_TIMEOUT - 1));
    // One warm-up target shared by the counter and the ready flag
    assign warm_target = power_mode_pkg::TIMER_W'(warmup_extend_input
                             ? power_mode_pkg::WARMUP_EXT_CYC
                             : power_mode_pkg::WARMUP_CYC);

    // Next mode and timers
    always_comb begin
        mode_next     = mode_reg;
        idle_cnt_next = idle_cnt_reg + 1'b1;
        wake_cnt_next = '0;
        if (wake_event) begin
            mode_next     = power_mode_pkg::MODE_ACTIVE;
            idle_cnt_next = '0;
        end else if (timeout || sw_force_step) begin
            idle_cnt_next = '0;
            case (mode_reg)
                power_mode_pkg::MODE_ACTIVE:
                    mode_next = power_mode_pkg::MODE_IDLE;
                power_mode_pkg::MODE_IDLE:
                    mode_next = power_mode_pkg::MODE_SLEEP;
                power_mode_pkg::MODE_SLEEP:
                    mode_next = power_mode_pkg::MODE_OFF;
                default:
                    mode_next = power_mode_pkg::MODE_OFF;
            endcase
        end else if (mode_reg == power_mode_pkg::MODE_OFF) begin
            idle_cnt_next = idle_cnt_reg;                   // Nothing lower
        end
        // Periodic self wake from low-power connection sleep
        if (lp_conn_enable && mode_reg == power_mode_pkg::MODE_SLEEP
            && !wake_event) begin
            wake_cnt_next = wake_cnt_reg + 1'b1;
            if (wake_cnt_reg
                == power_mode_pkg::TIMER_W'(WAKE_INTERVAL - 1)) begin
                mode_next     = power_mode_pkg::MODE_ACTIVE;
                idle_cnt_next = '0;
                wake_cnt_next = '0;
            end
        end
        // Crystal warm-up before granting a clock request
        if (!clk_request || mode_reg == power_mode_pkg::MODE_OFF)
            warm_cnt_next = '0;
        else if (warm_cnt_reg != warm_target)
            warm_cnt_next = warm_cnt_reg + 1'b1;
        else
            warm_cnt_next = warm_cnt_reg;
    end

    // Register state
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            mode_reg     <= power_mode_pkg::MODE_ACTIVE;
            idle_cnt_reg <= '0;
            wake_cnt_reg <= '0;
            warm_cnt_reg <= '0;
        end else begin
            mode_reg     <= mode_next;
            idle_cnt_reg <= idle_cnt_next;
            wake_cnt_reg <= wake_cnt_next;
            warm_cnt_reg <= warm_cnt_next;
        end
    end

    // ====================================================================
    // Outputs, all registered from next-state values
    logic radio_on_next, off_next, warm_done_next;
    always_comb begin
        off_next       = (mode_next == power_mode_pkg::MODE_OFF);
        radio_on_next  = !off_next && (pkt_tx_active || pkt_rx_active);
        warm_done_next = clk_request && (warm_cnt_next == warm_target);
    end

    // Radio blocks only powered while a packet is on the air
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            power_mode            <= 2'h0;
            core_supply_output_en <= 1'b1;
            amplifier_supply_en   <= 1'b1;
            core_regulator_en     <= 1'b1;
            slow_clock_sel        <= 1'b0;
            tx_pd                 <= 1'b1;
            rx_pd                 <= 1'b1;
            pll_pd                <= 1'b1;
            pa_pd                 <= 1'b1;
            device_to_host_wake   <= 1'b0;
            clk_ready             <= 1'b0;
        end else begin
            power_mode            <= mode_next;
            core_supply_output_en <= !off_next;
            amplifier_supply_en   <= !off_next;
            core_regulator_en     <= !off_next;
            slow_clock_sel        <= lp_conn_enable
                && mode_next == power_mode_pkg::MODE_SLEEP;
            tx_pd  <= !(radio_on_next && pkt_tx_active);
            rx_pd  <= !(radio_on_next && pkt_rx_active);
            pll_pd <= !radio_on_next;
            pa_pd  <= !(radio_on_next && pkt_tx_active);
            device_to_host_wake   <= dev_attention && !off_next;
            clk_ready             <= warm_done_next;
        end
    end

    // ====================================================================
    // Assertions
    a_wake_to_active: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        wake_event |=> power_mode == power_mode_pkg::MODE_ACTIVE)
        else $error("activity did not return to active");
    a_off_supplies: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        power_mode == power_mode_pkg::MODE_OFF
        |-> !core_supply_output_en && !amplifier_supply_en)
        else $error("supplies on in power-off");
    a_off_regulator: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        power_mode == power_mode_pkg::MODE_OFF |-> !core_regulator_en)
        else $error("regulator on in power-off");
    a_step_down: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        timeout && !wake_event && mode_reg == power_mode_pkg::MODE_ACTIVE
        && !(lp_conn_enable) |=> power_mode == power_mode_pkg::MODE_IDLE)
        else $error("no step down after timeout");
    a_timer_restart: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        $changed(mode_reg) |-> idle_cnt_reg == '0)
        else $error("timer not restarted on mode change");
    a_radio_idle: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        !pkt_tx_active && !pkt_rx_active
        |=> tx_pd && rx_pd && pll_pd && pa_pd)
        else $error("radio on outside packet");
    a_radio_tx: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        pkt_tx_active && mode_next != power_mode_pkg::MODE_OFF
        |=> !tx_pd && !pa_pd && !pll_pd)
        else $error("tx path not powered in packet");
    a_host_wake: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        dev_attention && host_to_device_wake |=> device_to_host_wake)
        else $error("host wake not driven");
    a_warmup_ext: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        $rose(clk_ready) && warmup_extend_input
        |-> warm_cnt_reg == power_mode_pkg::TIMER_W'(
            power_mode_pkg::WARMUP_EXT_CYC))
        else $error("extended warm-up not applied");
    a_slow_clock: assert property (
        @(posedge clk) disable iff (!rst_sync_n)
        slow_clock_sel |-> power_mode == power_mode_pkg::MODE_SLEEP)
        else $error("slow clock outside sleep");

    c_reach_off: cover property (@(posedge clk) disable iff (!rst_sync_n)
        power_mode == 2'h2);
    c_off_wake: cover property (@(posedge clk) disable iff (!rst_sync_n)
        power_mode == 2'h2 ##1 power_mode == 2'h0);
    c_lp_wake: cover property (@(posedge clk) disable iff (!rst_sync_n)
        slow_clock_sel ##1 power_mode == 2'h0);
    c_clk_ready: cover property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(clk_ready));

endmodule : activity_power_mode_sequencer

// >>> activity_power_mode_sequencer_tb.sv
// Self-checking bench for the activity power-mode sequencer.
// Assumes the package and the host model are compiled first.
`timescale 1ns/1ps
module activity_power_mode_sequencer_tb;
    // ==================================================
    // Stimulus, observed outputs and score keeping
    logic        clk = 0, rst_n = 0, act = 0, f_act = 0, f_step = 0;
    logic        lp = 0, tx = 0, rx = 0, want = 0, att = 0, wext = 0;
    logic        creq = 0, h2d, d2h, cready, slow, core, amp, regu;
    logic        txp, rxp, pllp, pap;
    logic [1:0]  mode;
    logic [10:0] q[$];
    int          err_count = 0, check_count = 0, n;
    localparam logic [1:0] M_ACT = power_mode_pkg::MODE_ACTIVE;
    localparam logic [1:0] M_IDLE = power_mode_pkg::MODE_IDLE;
    localparam logic [1:0] M_SLP = power_mode_pkg::MODE_SLEEP;
    localparam logic [1:0] M_OFF = power_mode_pkg::MODE_OFF;
    localparam int W_NORM = power_mode_pkg::WARMUP_CYC;
    localparam int W_EXT = power_mode_pkg::WARMUP_EXT_CYC;
    wire [10:0] obs = {mode, core, amp, regu, slow, txp, rxp, pllp, pap, d2h};
    always #5 clk = ~clk;
    // ==================================================
    // Short counts keep the step-down run brief
    activity_power_mode_sequencer #(.IDLE_TIMEOUT(16), .WAKE_INTERVAL(8))
    i_dut (.clk(clk), .rst_n(rst_n), .user_activity(act),
        .sw_force_active(f_act), .sw_force_step(f_step),
        .lp_conn_enable(lp), .pkt_tx_active(tx), .pkt_rx_active(rx),
        .host_to_device_wake(h2d), .dev_attention(att),
        .warmup_extend_input(wext), .clk_request(creq),
        .power_mode(mode), .core_supply_output_en(core),
        .amplifier_supply_en(amp), .core_regulator_en(regu),
        .slow_clock_sel(slow), .tx_pd(txp), .rx_pd(rxp), .pll_pd(pllp),
        .pa_pd(pap), .device_to_host_wake(d2h), .clk_ready(cready));
    host_model i_host (.clk(clk), .want(want),
        .device_to_host_wake(d2h), .host_to_device_wake(h2d));
    // ==================================================
    // Expected outputs; supplies drop only in power-off
    function automatic logic [10:0] ev(logic [1:0] m, logic t, r, a, s);
        logic on;
        on = (m != M_OFF);
        return {m, on, on, on, s, ~t, ~r, ~(t | r), ~t, a & on};
    endfunction : ev
    task automatic chk(logic [10:0] got, logic [10:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Note the result due after the coming edge
    task automatic expect_next(logic [10:0] v);
        @(posedge clk);
        q.push_back(v);
        @(negedge clk);
    endtask : expect_next
    // Bounded wait for a mode or for clock ready; n counts cycles
    task automatic wait_for(bit rdy, logic [1:0] m);
        n = 0;
        while ((rdy ? cready !== 1'b1 : mode !== m) && n < 300) begin
            @(negedge clk);
            n++;
        end
        if (n >= 300) begin
            err_count++;
            results();
        end
    endtask : wait_for
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // Monitor: outputs are settled by the falling edge
    always @(negedge clk) begin
        if (q.size() > 0) chk(obs, q.pop_front());
    end
    // ==================================================
    // Main sequence
    initial begin
        n = $urandom(32'h1ca8);
        expect_next(ev(M_ACT, 0, 0, 0, 0));
        repeat (3) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            act = 1;
            {tx, rx, att} = 3'($urandom);
            expect_next(ev(M_ACT, tx, rx, att, 0));
        end
        {tx, rx, att, act} = 4'b0010;
        $display("radio test done");
        wait_for(0, M_IDLE);
        wait_for(0, M_SLP);
        chk(11'(n), 11'd16);
        wait_for(0, M_OFF);
        chk(11'(n), 11'd16);
        expect_next(ev(M_OFF, 0, 0, 1, 0));
        act = 1;
        expect_next(ev(M_ACT, 0, 0, 1, 0));
        act = 0;
        $display("step-down test done");
        wait_for(0, M_IDLE);
        want <= 1;
        @(negedge clk);
        expect_next(ev(M_ACT, 0, 0, 1, 0));
        want <= 0;
        // Host line lags want by one cycle; let it drop before stepping
        @(negedge clk);
        f_step = 1;
        expect_next(ev(M_IDLE, 0, 0, 1, 0));
        f_step = 0;
        f_act = 1;
        expect_next(ev(M_ACT, 0, 0, 1, 0));
        {f_act, lp, f_step} = 3'b011;
        expect_next(ev(M_IDLE, 0, 0, 1, 0));
        expect_next(ev(M_SLP, 0, 0, 1, 1));
        f_step = 0;
        wait_for(0, M_ACT);
        chk(11'(n >= 7 && n <= 9), 11'd1);
        lp = 0;
        $display("host and software test done");
        act = 1;
        for (int e = 0; e < 2; e++) begin
            wext = e[0];
            creq = 1;
            wait_for(1, M_ACT);
            chk(11'(n), 11'(e ? W_EXT : W_NORM));
            creq = 0;
            repeat (3) @(negedge clk);
        end
        $display("warm-up test done");
        results();
    end
endmodule : activity_power_mode_sequencer_tb

// >>> host_model.sv
// Host-side partner: raises its wake line toward the device on request.
// Assumes the bench changes want on the falling edge of clk.
`timescale 1ns/1ps
module host_model (
    // Clock and request from the bench
    input  wire logic clk,
    input  wire logic want,
    // Wake lines
    input  wire logic device_to_host_wake,
    output logic      host_to_device_wake
);
    // ==================================================
    // Wake level changes away from the sampling edge
    initial host_to_device_wake = 1'b0;
    always @(negedge clk) begin
        host_to_device_wake <= want;
    end
endmodule : host_model

// >>> power_mode_pkg.sv
// Package for the activity power-mode sequencer.
// Assumes a single 100 MHz clock domain; no imports are used anywhere.
package power_mode_pkg;

    // ====================================================================
    // Power modes, Gray coded along active > idle > sleep > off
    typedef enum logic [1:0] {
        MODE_ACTIVE = 2'h0,
        MODE_IDLE   = 2'h1,
        MODE_SLEEP  = 2'h3,
        MODE_OFF    = 2'h2
    } power_mode_type;

    // ====================================================================
    // Timing
    localparam int CLK_PERIOD_NS      = 10;
    localparam int IDLE_TIMEOUT_US    = 100;
    localparam int IDLE_TIMEOUT_CYC   = IDLE_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
    localparam int WARMUP_NS          = 200;
    localparam int WARMUP_CYC         = (WARMUP_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;
    localparam int WARMUP_EXT_NS      = 800;
    localparam int WARMUP_EXT_CYC     = (WARMUP_EXT_NS + CLK_PERIOD_NS - 1)
                                        / CLK_PERIOD_NS;
    localparam int WAKE_INTERVAL_US   = 50;
    localparam int WAKE_INTERVAL_CYC  = WAKE_INTERVAL_US * 1000
                                        / CLK_PERIOD_NS;
    localparam int TIMER_W            = 24;

endpackage : power_mode_pkg
